// File: core/asrbt_pkg.sv
// package of timing constants, widths and states for the static memory bus controller
package asrbt_pkg;
   // clock of the controller
   localparam int CLK_PERIOD_PS         = 25000;  // 40 mhz clock period in ps
   // memory geometry
   localparam int ADDR_W                = 19;     // word address width
   localparam int DATA_W                = 16;     // data bus width
   localparam int BYTE_W                = 8;      // width of one byte lane
   localparam int LANES                 = 2;      // byte lanes on the bus
   // read timing in ns, fast grade
   localparam int READ_CYCLE_MIN_NS     = 45;     // shortest read cycle
   localparam int ADDR_TO_VALID_NS      = 45;     // address to data valid, max
   localparam int SELECT_TO_VALID_NS    = 45;     // chip select to data valid, max
   localparam int GATE_TO_VALID_NS      = 22;     // output gate to data valid, max
   localparam int BYTE_SEL_TO_VALID_NS  = 45;     // byte select to data valid, max
   localparam int GATE_TO_RELEASE_NS    = 18;     // output gate high to bus float, max
   // write timing in ns, fast grade
   localparam int WRITE_CYCLE_MIN_NS    = 45;     // shortest write cycle
   localparam int WRITE_PULSE_MIN_NS    = 35;     // shortest write strobe low time
   localparam int ADDR_SETUP_TO_END_NS  = 35;     // address stable before write end
   localparam int BYTE_SEL_TO_END_NS    = 35;     // byte select low before write end
   localparam int DATA_SETUP_NS         = 25;     // data setup before write end
   localparam int STROBE_TO_RELEASE_NS  = 18;     // write strobe low to bus float, max
   // cycle counts: least times round up
   localparam int READ_CYCLES  = (READ_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WAIT_MAX_NS  = (ADDR_TO_VALID_NS > BYTE_SEL_TO_VALID_NS) ?
                                 ADDR_TO_VALID_NS : BYTE_SEL_TO_VALID_NS;
   localparam int SAMPLE_CYCLES = (WAIT_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
   localparam int PULSE_NS_A   = (WRITE_PULSE_MIN_NS > ADDR_SETUP_TO_END_NS) ?
                                 WRITE_PULSE_MIN_NS : ADDR_SETUP_TO_END_NS;
   localparam int PULSE_NS_B   = (PULSE_NS_A > BYTE_SEL_TO_END_NS) ? PULSE_NS_A : BYTE_SEL_TO_END_NS;
   localparam int PULSE_NS     = (PULSE_NS_B > DATA_SETUP_NS + STROBE_TO_RELEASE_NS) ?
                                 PULSE_NS_B : DATA_SETUP_NS + STROBE_TO_RELEASE_NS;
   localparam int PULSE_CYCLES = (PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYCLES = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RELEASE_CYCLES = (GATE_TO_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W        = 4;              // width of the phase counter
   // controller states, one-hot
   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_READ  = 4'b0010,
      ST_WRITE = 4'b0100,
      ST_GAP   = 4'b1000
   } asrbt_state_t;
endpackage

// File: core/asrbt_timer.sv
// down counter that times one phase of a bus cycle
`timescale 1ns/1ps
module asrbt_timer #(
   parameter int CNT_W = 4
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             reset_in,
   // control
   input  wire logic             load_in,    // start a new phase
   input  wire logic [CNT_W-1:0] count_in,   // cycles in the phase
   // status
   output logic                  done_out    // phase has run out
);
   logic [CNT_W-1:0] cnt_r;                  // cycles still to go

   // reload on request, else count down to zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cnt_r <= '0;
      end else if (load_in) begin
         cnt_r <= count_in;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // done does not look at load_in: the controller builds its load from done, and
   // feeding the load back here would close a combinational loop
   assign done_out = (cnt_r == '0);
endmodule

// File: core/asrbt_ctrl.sv
// controller that runs read and write cycles on an asynchronous static memory bus
//
// What the memory bus requires
// [R01] read cycle at least 45 ns, data by then
// [R02] memory holds old data 10 ns
// [R03] valid data 45 ns after chip select
// [R04] valid data 22 ns after output gate
// [R05] byte lane valid 45 ns after select
// [R06] memory drives lane no earlier than 5 ns
// [R07] memory releases bus faster than turning on
// [R08] write needs all selects; strobe low 35 ns
// [R09] data set 25 ns before write end
// [R10] address stable 35 ns before write end
// [R11] address zero setup and zero hold
// [R12] byte select low 35 ns before end
// [R13] write cycles spaced at least 45 ns
// [R14] memory deselected by chip or byte selects
// [R15] write strobe high through every read
// [R16] memory floats data while gate high writing
// [R17] never drive while memory drives data
// [R18] memory floats when both chip selects drop
// [R19] byte selects gate lanes; others float
// [R20] round minimums up, wait out maximums
`timescale 1ns/1ps
module asrbt_ctrl #(
   parameter int ADDR_W = asrbt_pkg::ADDR_W,
   parameter int DATA_W = asrbt_pkg::DATA_W
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              reset_in,
   // user request port
   input  wire logic              req_valid_in,     // request pending
   input  wire logic              req_write_in,     // 1 write, 0 read
   input  wire logic [ADDR_W-1:0] req_addr_in,      // word address
   input  wire logic [DATA_W-1:0] req_wdata_in,     // write data
   input  wire logic [1:0]        req_lanes_in,     // lane enables, bit0 low byte
   output logic                   req_ready_out,    // request taken this cycle
   // user answer port
   output logic                   rd_valid_out,     // read data pulse
   output logic [DATA_W-1:0]      rd_data_out,      // read data, unselected lanes zero
   // memory pins
   output logic [ADDR_W-1:0]      mem_addr_out,     // address pins
   output logic                   chip_select_n_out,
   output logic                   chip_select_hi_out,
   output logic                   write_strobe_n_out,
   output logic                   out_gate_n_out,
   output logic                   upper_byte_sel_n_out,
   output logic                   lower_byte_sel_n_out,
   input  wire logic [DATA_W-1:0] mem_data_in,      // data pins, level seen
   output logic [DATA_W-1:0]      mem_data_out,     // data we drive
   output logic [DATA_W-1:0]      mem_data_oe_out   // high while we drive the bit
);
   localparam int CW = asrbt_pkg::CNT_W;
   localparam int BW = asrbt_pkg::BYTE_W;

   ////////////////////////////////////////////////////////////////////////////
   // state and registers
   asrbt_pkg::asrbt_state_t state_r, state_nxt;    // cycle sequencer
   logic [ADDR_W-1:0]  addr_r;                      // latched address
   logic [DATA_W-1:0]  wdata_r;                     // latched write data
   logic [1:0]         lanes_r;                     // latched lane enables
   logic               sel_r;                       // chip selected
   logic               wr_r;                        // write strobe active
   logic               gate_r;                      // output gate active
   logic               drive_r;                     // we drive data pins
   logic [DATA_W-1:0]  rdata_r;                     // captured read data
   logic               rvalid_r;                    // read data pulse
   logic [DATA_W-1:0]  sync1_r, sync2_r;            // data pin synchroniser
   logic [CW-1:0]      phase_r;                     // cycles spent in the read phase
   logic               was_read_r;                  // last cycle was a read

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic idle_st   = (state_r == asrbt_pkg::ST_IDLE);
   wire logic read_st   = (state_r == asrbt_pkg::ST_READ);
   wire logic write_st  = (state_r == asrbt_pkg::ST_WRITE);
   wire logic gap_st    = (state_r == asrbt_pkg::ST_GAP);
   wire logic take      = idle_st && req_valid_in && (req_lanes_in != 2'b00);
   wire logic done;                                  // phase timer ran out
   // sampling waits out the longest max delay plus the two synchroniser stages
   wire logic rd_sample = read_st && (phase_r == CW'(asrbt_pkg::SAMPLE_CYCLES + 1)); // see [R20]
   // read holds for its minimum and until its sample is taken
   wire logic rd_end    = read_st && done && rd_sample;  // see [R01]
   wire logic wr_end    = write_st && done;              // see [R08]
   wire logic [CW-1:0] load_cnt =
      take ? (req_write_in ? CW'(asrbt_pkg::PULSE_CYCLES)          // see [R12]
                           : CW'(asrbt_pkg::SAMPLE_CYCLES + 1))    // see [R01]
           : CW'(asrbt_pkg::WRITE_CYCLES - asrbt_pkg::PULSE_CYCLES + // see [R13]
                 (was_read_r ? asrbt_pkg::RELEASE_CYCLES : 0));       // see [R17]
   wire logic load      = take || rd_end || wr_end;

   ////////////////////////////////////////////////////////////////////////////
   // phase timer
   asrbt_timer #(.CNT_W(CW)) u_timer (
      .clk_in   (clk_in),
      .reset_in (reset_in),
      .load_in  (load),
      .count_in (load_cnt),
      .done_out (done)
   );

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         asrbt_pkg::ST_IDLE: begin
            if (take) begin
               state_nxt = req_write_in ? asrbt_pkg::ST_WRITE : asrbt_pkg::ST_READ;
            end
         end
         asrbt_pkg::ST_READ: begin
            if (rd_end) begin
               state_nxt = asrbt_pkg::ST_GAP;
            end
         end
         asrbt_pkg::ST_WRITE: begin
            if (wr_end) begin
               state_nxt = asrbt_pkg::ST_GAP;
            end
         end
         asrbt_pkg::ST_GAP: begin
            if (done) begin
               state_nxt = asrbt_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = asrbt_pkg::ST_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and pin registers
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_r    <= asrbt_pkg::ST_IDLE;
         addr_r     <= '0;
         wdata_r    <= '0;
         lanes_r    <= 2'b00;
         sel_r      <= 1'b0;
         wr_r       <= 1'b0;
         gate_r     <= 1'b0;
         drive_r    <= 1'b0;
         phase_r    <= '0;
         was_read_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // address, data and lanes settle with the selects, zero setup allowed
         if (take) begin
            addr_r     <= req_addr_in;              // see [R11]
            wdata_r    <= req_wdata_in;             // see [R09]
            lanes_r    <= req_lanes_in;             // see [R19]
            sel_r      <= 1'b1;
            wr_r       <= req_write_in;             // see [R15]
            gate_r     <= !req_write_in;            // gate stays high while writing
            drive_r    <= req_write_in;             // see [R17]
            was_read_r <= !req_write_in;
            phase_r    <= '0;
         end else if (rd_end || wr_end) begin
            // every control goes inactive together; address and data held one more edge
            sel_r   <= 1'b0;
            wr_r    <= 1'b0;                        // see [R10]
            gate_r  <= 1'b0;
            lanes_r <= 2'b00;
         end else if (gap_st) begin
            drive_r <= 1'b0;                        // data held one cycle after the write end, released in the gap
         end
         if (read_st) begin
            phase_r <= phase_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data pin synchroniser and capture
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         sync1_r  <= '0;
         sync2_r  <= '0;
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end else begin
         sync1_r  <= mem_data_in;
         sync2_r  <= sync1_r;
         rvalid_r <= rd_sample;
         if (rd_sample) begin
            // unselected lanes are floating, so they are masked off
            rdata_r <= sync2_r & {{BW{lanes_r[1]}}, {BW{lanes_r[0]}}}; // see [R19]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign req_ready_out        = take;
   assign rd_valid_out         = rvalid_r;
   assign rd_data_out          = rdata_r;
   assign mem_addr_out         = addr_r;
   assign chip_select_n_out    = !sel_r;
   assign chip_select_hi_out   = sel_r;
   assign write_strobe_n_out   = !wr_r;            // see [R08]
   assign out_gate_n_out       = !gate_r;
   assign upper_byte_sel_n_out = !lanes_r[1];
   assign lower_byte_sel_n_out = !lanes_r[0];
   assign mem_data_out         = wdata_r;
   // only selected lanes are driven, and only in a write and the gap cycle after it
   assign mem_data_oe_out      = {{BW{drive_r && wdata_lane(1)}}, {BW{drive_r && wdata_lane(0)}}};

   // lane enable loaded at each take and held until the next take; drive_r ends the drive
   logic [1:0] drive_lanes_r;
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         drive_lanes_r <= 2'b00;
      end else if (take) begin
         drive_lanes_r <= req_lanes_in;             // see [R19]
      end
   end

   function automatic logic wdata_lane(input int idx);
      wdata_lane = drive_lanes_r[idx];
   endfunction
endmodule

// File: tb/asrbt_ctrl_assertions.sv
// pin timing checker for the static memory bus controller
`timescale 1ns/1ps
module asrbt_ctrl_chk #(parameter int ADDR_W = 19, parameter int DATA_W = 16) (
   // clock, reset and user side
   input wire logic clk_in, reset_in, req_valid_in, req_write_in, req_ready_out, rd_valid_out,
   // memory pins
   input wire logic [ADDR_W-1:0] mem_addr_out,
   input wire logic chip_select_n_out, chip_select_hi_out, write_strobe_n_out,
   input wire logic out_gate_n_out, upper_byte_sel_n_out, lower_byte_sel_n_out,
   input wire logic [DATA_W-1:0] mem_data_out, mem_data_oe_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // a read taken at the user port, and the first cycle of a write strobe
   sequence rd_take; req_valid_in && req_ready_out && !req_write_in; endsequence
   sequence strobe_on; $fell(write_strobe_n_out); endsequence
   chk_read_no_strobe: assert property (!out_gate_n_out |-> write_strobe_n_out)
      else $error("strobe low while output gate low");
   chk_write_all_sel: assert property (!write_strobe_n_out |-> !chip_select_n_out &&
      chip_select_hi_out && !(upper_byte_sel_n_out && lower_byte_sel_n_out))
      else $error("strobe low without full select");
   chk_strobe_width: assert property (strobe_on |-> ##1 !write_strobe_n_out)
      else $error("strobe pulse too short");
   chk_write_held: assert property (
      (!write_strobe_n_out && !$past(write_strobe_n_out))
      |-> $stable(mem_addr_out) && $stable(mem_data_out))
      else $error("address or data moved in write");
   chk_lane_drive: assert property (!write_strobe_n_out |-> mem_data_oe_out ==
      {{8{!upper_byte_sel_n_out}}, {8{!lower_byte_sel_n_out}}})
      else $error("driven lanes differ from byte selects");
   chk_no_drive_rd: assert property (!out_gate_n_out |-> mem_data_oe_out == 16'h0000)
      else $error("bus driven during read");
   chk_read_length: assert property ($fell(out_gate_n_out) |->
      (!out_gate_n_out && !chip_select_n_out)[*3])
      else $error("read cycle too short");
   chk_data_hold: assert property ($rose(write_strobe_n_out) |->
      mem_data_oe_out == $past(mem_data_oe_out))
      else $error("data released at write end");
   chk_write_gap: assert property ($rose(write_strobe_n_out) |->
      ##1 write_strobe_n_out)
      else $error("write cycles too close");
   chk_read_answer: assert property (rd_take |-> ##[3:12] rd_valid_out)
      else $error("read answer missing");
endmodule
bind asrbt_ctrl asrbt_ctrl_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.clk_in(clk_in),
   .reset_in(reset_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in),
   .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .mem_addr_out(mem_addr_out),
   .chip_select_n_out(chip_select_n_out), .chip_select_hi_out(chip_select_hi_out),
   .write_strobe_n_out(write_strobe_n_out), .out_gate_n_out(out_gate_n_out),
   .upper_byte_sel_n_out(upper_byte_sel_n_out), .lower_byte_sel_n_out(lower_byte_sel_n_out),
   .mem_data_out(mem_data_out), .mem_data_oe_out(mem_data_oe_out));

// File: tb/asrbt_mem_model.sv
// behavioural static memory that answers the controller's pins
`timescale 1ns/1ps
module asrbt_mem_model (
   // pins from the controller
   input  wire logic [18:0] addr_in,
   input  wire logic        cs_n_in, cs_hi_in, we_n_in, oe_n_in, ub_n_in, lb_n_in,
   input  wire logic [15:0] data_in,  // resolved bus level
   input  wire logic        slow_in,  // answer near the slowest legal time
   output logic      [15:0] data_out,
   output logic      [15:0] data_oe_out
);
   logic [15:0] mem [0:(1<<19)-1];  // contents
   logic [15:0] word;               // word at the read address
   realtime     t_on;               // when the current write began
   wire sel = !cs_n_in && cs_hi_in && !(ub_n_in && lb_n_in);
   wire wr = sel && !we_n_in;
   wire rd = sel && we_n_in && !oe_n_in;
   wire [15:0] lanes = {{8{!ub_n_in}}, {8{!lb_n_in}}};
   wire on_f, on_s;
   wire [18:0] a_r, a_w;
   wire [15:0] m_w, d_w;
   assign #10 on_f = rd;  // no drive before 10 ns, release at once
   assign #45 on_s = rd;  // slow answer still in time
   assign #10 a_r = addr_in;  // old word stands 10 ns after an address change
   // the store uses what stood at the set-up limits before the ending edge, so a late
   // address, byte select or data value lands wrongly and the read back shows it;
   // sampling early also keeps the store clear of the race among the ending pins
   assign #35 a_w = addr_in;
   assign #35 m_w = lanes;
   assign #25 d_w = data_in & lanes;
   always @(posedge wr) t_on = $realtime;
   // a strobe shorter than the minimum stores nothing, as when reset cuts a write
   always @(negedge wr) begin
      if ($realtime - t_on >= 35.0) begin
         mem[a_w] = (mem[a_w] & ~m_w) | (d_w & m_w);
      end
   end
   // invalid data shows inverted until the access time has passed
   always @* begin
      word = mem[a_r];
      data_out = (slow_in ? on_s : on_f) ? word : ~word;
      data_oe_out = (rd && on_f) ? lanes : 16'h0000;
   end
endmodule

// File: tb/asrbt_ctrl_tb.sv
// self-checking bench for the static memory bus controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module asrbt_ctrl_tb;
   logic clk_in = 0, reset_in = 1, req_valid_in = 0, req_write_in = 0, slow = 0, flip = 0;
   logic took = 0, req_ready_out, rd_valid_out, cs_n, cs_hi, we_n, oe_n, ub_n, lb_n;
   logic [18:0] req_addr_in = 0, mem_addr_out, a, pool [8];
   logic [15:0] req_wdata_in = 0, rd_data_out, bus, c_d, c_oe, d_d, d_oe, shadow [int];
   logic [1:0]  req_lanes_in = 1, l;
   int failures = 0, check_count = 0;
   initial forever #12.5 clk_in = ~clk_in;
   // take marker; an unowned bus shows a pattern that flips each cycle
   always @(posedge clk_in) begin flip <= ~flip; took <= req_valid_in & req_ready_out; end
   assign bus = (c_oe & c_d) | (~c_oe & d_oe & d_d) | (~c_oe & ~d_oe & {16{flip}});
   asrbt_ctrl uut (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
      .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
      .req_lanes_in(req_lanes_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
      .rd_data_out(rd_data_out), .mem_addr_out(mem_addr_out), .chip_select_n_out(cs_n),
      .chip_select_hi_out(cs_hi), .write_strobe_n_out(we_n), .out_gate_n_out(oe_n),
      .upper_byte_sel_n_out(ub_n), .lower_byte_sel_n_out(lb_n), .mem_data_in(bus),
      .mem_data_out(c_d), .mem_data_oe_out(c_oe));
   asrbt_mem_model mem_i (.addr_in(mem_addr_out), .cs_n_in(cs_n), .cs_hi_in(cs_hi),
      .we_n_in(we_n), .oe_n_in(oe_n), .ub_n_in(ub_n), .lb_n_in(lb_n), .data_in(bus),
      .slow_in(slow), .data_out(d_d), .data_oe_out(d_oe));
   // one request, held until the controller takes it
   task automatic req(input logic w, input logic [18:0] ad, input logic [15:0] d,
                      input logic [1:0] ln);
      int n;
      @(negedge clk_in);
      req_valid_in = 1; req_write_in = w; req_addr_in = ad; req_wdata_in = d; req_lanes_in = ln;
      for (n = 0; n < 40 && !took; n++) @(negedge clk_in);
      req_valid_in = 0;
      `CHK("take", 1'b1, took)
   endtask
   function automatic logic [15:0] lane_mask(logic [1:0] ln);
      return {{8{ln[1]}}, {8{ln[0]}}};
   endfunction
   task automatic wr(input logic [18:0] ad, input logic [15:0] d, input logic [1:0] ln);
      req(1, ad, d, ln);
      shadow[ad] = (shadow[ad] & ~lane_mask(ln)) | (d & lane_mask(ln));
   endtask
   task automatic rd(input logic [18:0] ad, input logic [1:0] ln);
      int n;
      req(0, ad, 16'h0000, ln);
      for (n = 0; n < 20 && rd_valid_out !== 1'b1; n++) @(negedge clk_in);
      `CHK("rd_valid", 1'b1, rd_valid_out)
      `CHK("rd_data", shadow[ad] & lane_mask(ln), rd_data_out)
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // watchdog: about three times the 500 cycles that the tests need
   initial begin repeat (1500) @(posedge clk_in); failures++; results(); end
   initial begin
      void'($urandom(29));
      repeat (16) @(negedge clk_in);
      reset_in = 0;
      pool[0] = 19'h00000; pool[1] = 19'h7ffff; // address extremes
      for (int i = 2; i < 8; i++) pool[i] = 19'($urandom);
      foreach (pool[i]) wr(pool[i], 16'($urandom), 2'h3);
      // back to back lane writes merge into one word
      wr(pool[1], 16'ha55a, 2'h1);
      wr(pool[1], 16'h3cc3, 2'h2);
      rd(pool[1], 2'h3);
      for (int k = 1; k < 4; k++) rd(pool[0], 2'(k));
      $display("test lanes done");
      repeat (60) begin
         a = pool[$urandom_range(7)]; l = 2'($urandom_range(3, 1)); slow = $urandom_range(1);
         if ($urandom_range(1)) wr(a, 16'($urandom), l);
         else rd(a, l);
      end
      $display("test random done");
      // reset right after a write is taken: nothing stored, pins idle
      req(1, pool[2], 16'hffff, 2'h3);
      reset_in = 1;
      @(negedge clk_in);
      `CHK("idle pins", 7'b1011110, {cs_n, cs_hi, we_n, oe_n, ub_n, lb_n, rd_valid_out})
      `CHK("data oe", 16'h0000, c_oe)
      reset_in = 0;
      rd(pool[2], 2'h3);
      $display("test reset done");
      results();
   end
endmodule
